// [core/reset_cause_map.vh]
// Register map, field positions, reset values and timing constants of the reset-cause block.
`ifndef RESET_CAUSE_MAP_VH
`define RESET_CAUSE_MAP_VH
// =====================================================================
// Register byte addresses
`define RC_ADDR_POWER_STATUS 12'h000
`define RC_ADDR_CORE_STATUS 12'h004
`define RC_ADDR_PC 12'h008
`define RC_ADDR_INT_CONTROL 12'h00C
`define RC_ADDR_PC_UPPER 12'h010
`define RC_ADDR_CONTROL 12'h014
`define RC_ADDR_SEQ_STATE 12'h018
// =====================================================================
// Field positions
`define RC_BIT_BROWNOUT 0
`define RC_BIT_POWERON 1
`define RC_BIT_POWERDOWN 3
`define RC_BIT_TIMEOUT 4
`define RC_BIT_GLOBAL_INT_ENABLE 7
// =====================================================================
// Reset values
`define RC_CORE_STATUS_POR 8'h18
`define RC_INT_CONTROL_POR 8'h00
`define RC_PC_UPPER_POR 5'h00
`define RC_PC_RESET 13'h0000
`define RC_PC_VECTOR 13'h0004
// =====================================================================
// Timing
`define RC_POWERUP_MS 72
`define RC_STARTUP_TOSC 1024
`define RC_CLK_MHZ 100
`endif

// [core/reset_cause_and_timeout.v]
// Reset-cause recording and start-up time-out sequencer with an AHB-Lite register slave.
//
// Functional notes
// - Power status register holds two flag bits.
// - Bit 0 brown-out flag, cleared on brown-out.
// - Brown-out flag invalid when detection disabled.
// - Bit 1 power-on flag, cleared only by power-on; the code also lets a software write of 0 clear it.
// - Power-up delays per oscillator mode and timer.
// - Flag encodings per reset and wake cause.
// - Power-on always sets time-out flag.
// - Power-on always sets power-down flag.
// - Pin reset and interrupt wake flag effects.
// - Resets load zero; wakes resume next address.
// - Interrupt wake with global enable vectors.
// - Core status reset values per reset type.
// - Core status values on sleep wake-ups.
// - Interrupt control and upper latch reset values.
// - Wake-ups set an interrupt flag bit.
// - Data registers undefined only after power/brown-out.
// - Unimplemented bits read as zero.
// - Brown-out enable forces power-up timer on.
// - Start-up delay only crystal, power-on, wake; in crystal mode the code also runs it after brown-out.
//
// The AHB-Lite register port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`include "reset_cause_map.vh"
module reset_cause_and_timeout #(
	parameter integer POWERUP_CYCLES = `RC_POWERUP_MS * `RC_CLK_MHZ * 1000,
	parameter integer STARTUP_CYCLES = `RC_STARTUP_TOSC
)(
	input wire clk,
	input wire sys_rst,
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output reg [31:0] hrdata,
	output reg hreadyout,
	output reg hresp,
	input wire powerOnEvent,
	input wire brownoutEvent,
	input wire externalResetPin,
	input wire watchdogEvent,
	input wire interruptEvent,
	input wire sleepRequest,
	input wire crystalMode,
	input wire powerupTimerEnable_n,
	input wire brownoutEnable,
	output reg coreResetHold,
	output reg coreSleeping,
	output reg [12:0] programCounter,
	output reg pcLoad,
	output reg wakeFlagSet
);
	// ===================================================================
	// Sequencer states
	localparam [3:0] ST_RUN = 4'b0001;
	localparam [3:0] ST_POWERUP = 4'b0010;
	localparam [3:0] ST_STARTUP = 4'b0100;
	localparam [3:0] ST_SLEEP = 4'b1000;
	localparam [1:0] TR_NONSEQ = 2'b10;
	reg [3:0] state_q;
	reg [31:0] count_q;
	reg brownoutFlag_n_q;
	reg poweronFlag_n_q;
	reg [7:0] coreStatus_q;
	reg [7:0] intControl_q;
	reg [4:0] pcUpper_q;
	reg [12:0] pcNext_q;
	reg wakeVector_q;
	reg wakePending_q;
	reg wrPending_q;
	reg [11:0] addr_q;
	wire [7:0] powerStatus;
	wire takeTransfer;
	wire useTimer;
	wire hwReset;
	wire intWake;
	// Brown-out enable forces the power-up timer on.
	assign useTimer = ~powerupTimerEnable_n | brownoutEnable;
	// A reset in the same cycle blocks a software write to the interrupt control or upper latch register; an interrupt wake only keeps the flag bit set.
	assign hwReset = powerOnEvent | (brownoutEvent & brownoutEnable) | externalResetPin |
		(watchdogEvent & (state_q != ST_SLEEP));
	assign intWake = interruptEvent & (state_q == ST_SLEEP);
	// Only two low bits of the power status register exist.
	assign powerStatus = {6'h00, poweronFlag_n_q, brownoutFlag_n_q};
	assign takeTransfer = hsel & hready & htrans[1];
	// ===================================================================
	// Reset sequencer and core state
	// Each reset source loads its own core state; power-on and brown-out then run the delay chain, pin and watchdog resets go straight to run.
	always @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			state_q <= ST_RUN;
			count_q <= 32'h0000_0000;
			brownoutFlag_n_q <= 1'b1;
			poweronFlag_n_q <= 1'b1;
			coreStatus_q <= `RC_CORE_STATUS_POR;
			intControl_q <= `RC_INT_CONTROL_POR;
			pcUpper_q <= `RC_PC_UPPER_POR;
			programCounter <= `RC_PC_RESET;
			pcNext_q <= `RC_PC_RESET;
			pcLoad <= 1'b0;
			coreResetHold <= 1'b0;
			coreSleeping <= 1'b0;
			wakeFlagSet <= 1'b0;
			wakeVector_q <= 1'b0;
			wakePending_q <= 1'b0;
		end
		else
		begin
			pcLoad <= 1'b0;
			wakeFlagSet <= 1'b0;
			if (powerOnEvent)
			begin
				poweronFlag_n_q <= 1'b0;
				// Brown-out flag left as is: undefined after power-on.
				coreStatus_q <= `RC_CORE_STATUS_POR;
				intControl_q <= `RC_INT_CONTROL_POR;
				pcUpper_q <= `RC_PC_UPPER_POR;
				programCounter <= `RC_PC_RESET;
				pcLoad <= 1'b1;
				coreResetHold <= 1'b1;
				coreSleeping <= 1'b0;
				count_q <= 32'h0000_0000;
				wakePending_q <= 1'b0;
				// Power-up timer first when used, else crystal start-up, else run.
				state_q <= useTimer ? ST_POWERUP : (crystalMode ? ST_STARTUP : ST_RUN);
				if (!useTimer && !crystalMode)
					coreResetHold <= 1'b0;
			end
			else if (brownoutEvent && brownoutEnable)
			begin
				brownoutFlag_n_q <= 1'b0;
				coreStatus_q[`RC_BIT_TIMEOUT] <= 1'b1;
				coreStatus_q[`RC_BIT_POWERDOWN] <= 1'b1;
				coreStatus_q[7:5] <= 3'h0;
				intControl_q <= `RC_INT_CONTROL_POR;
				pcUpper_q <= `RC_PC_UPPER_POR;
				programCounter <= `RC_PC_RESET;
				pcLoad <= 1'b1;
				coreResetHold <= 1'b1;
				coreSleeping <= 1'b0;
				count_q <= 32'h0000_0000;
				wakePending_q <= 1'b0;
				// Brown-out always runs the power-up timer; it then adds 1024 periods in crystal mode.
				state_q <= ST_POWERUP;
			end
			// A watchdog time-out while asleep is a wake-up, handled by the sequencer below.
			else if (externalResetPin || (watchdogEvent && state_q != ST_SLEEP))
			begin
				if (state_q == ST_SLEEP && externalResetPin)
				begin
					coreStatus_q[`RC_BIT_TIMEOUT] <= 1'b1;
					coreStatus_q[`RC_BIT_POWERDOWN] <= 1'b0;
				end
				else if (externalResetPin == 1'b0)
				begin
					coreStatus_q[`RC_BIT_TIMEOUT] <= 1'b0;
					coreStatus_q[`RC_BIT_POWERDOWN] <= 1'b1;
				end
				coreStatus_q[7:5] <= 3'h0;
				intControl_q[7:1] <= 7'h00;
				pcUpper_q <= `RC_PC_UPPER_POR;
				programCounter <= `RC_PC_RESET;
				pcLoad <= 1'b1;
				coreSleeping <= 1'b0;
				coreResetHold <= 1'b0;
				wakePending_q <= 1'b0;
				// Core data registers are not touched here, so they keep their values.
				state_q <= ST_RUN;
			end
			else
			begin
				case (state_q)
					ST_POWERUP:
					begin
						if (count_q >= POWERUP_CYCLES - 1)
						begin
							count_q <= 32'h0000_0000;
							state_q <= crystalMode ? ST_STARTUP : ST_RUN;
							if (!crystalMode)
								coreResetHold <= 1'b0;
						end
						else
							count_q <= count_q + 32'h0000_0001;
					end
					ST_STARTUP:
					begin
						if (count_q >= STARTUP_CYCLES - 1)
						begin
							count_q <= 32'h0000_0000;
							state_q <= ST_RUN;
							coreResetHold <= 1'b0;
							coreSleeping <= 1'b0;
							if (wakePending_q)
							begin
								wakePending_q <= 1'b0;
								programCounter <= wakeVector_q ? `RC_PC_VECTOR : pcNext_q;
								pcLoad <= 1'b1;
							end
						end
						else
							count_q <= count_q + 32'h0000_0001;
					end
					ST_SLEEP:
					begin
						if (interruptEvent)
						begin
							coreStatus_q[`RC_BIT_TIMEOUT] <= 1'b1;
							coreStatus_q[`RC_BIT_POWERDOWN] <= 1'b0;
							intControl_q[0] <= 1'b1;
							wakeFlagSet <= 1'b1;
							wakeVector_q <= intControl_q[`RC_BIT_GLOBAL_INT_ENABLE];
						end
						else if (watchdogEvent)
						begin
							coreStatus_q[`RC_BIT_TIMEOUT] <= 1'b0;
							coreStatus_q[`RC_BIT_POWERDOWN] <= 1'b0;
							wakeFlagSet <= 1'b1;
							wakeVector_q <= 1'b0;
						end
						// Both wake sources resume at the next address, except an interrupt wake with global enable set, which vectors; no start-up delay in RC mode.
						if (interruptEvent || watchdogEvent)
						begin
							count_q <= 32'h0000_0000;
							wakePending_q <= 1'b1;
							if (crystalMode)
								state_q <= ST_STARTUP;
							else
							begin
								state_q <= ST_RUN;
								coreSleeping <= 1'b0;
								wakePending_q <= 1'b0;
								programCounter <= (interruptEvent && intControl_q[`RC_BIT_GLOBAL_INT_ENABLE]) ?
									`RC_PC_VECTOR : pcNext_q;
								pcLoad <= 1'b1;
							end
						end
					end
					ST_RUN:
					begin
						if (sleepRequest)
						begin
							state_q <= ST_SLEEP;
							coreSleeping <= 1'b1;
							pcNext_q <= programCounter + 13'h0001;
						end
					end
					default:
						state_q <= ST_RUN;
				endcase
			end
			// Software writes only the flag bits, each to the written value; a power-on event in the same cycle blocks the write, a brown-out only the brown-out flag's.
			if (wrPending_q && addr_q == `RC_ADDR_POWER_STATUS && !powerOnEvent)
			begin
				poweronFlag_n_q <= hwdata[`RC_BIT_POWERON];
				if (!(brownoutEvent && brownoutEnable))
					brownoutFlag_n_q <= hwdata[`RC_BIT_BROWNOUT];
			end
			// Writes lose against any reset; an interrupt wake still sets its flag bit.
			if (wrPending_q && addr_q == `RC_ADDR_INT_CONTROL && !hwReset)
				intControl_q <= {hwdata[7:1], hwdata[0] | intWake};
			if (wrPending_q && addr_q == `RC_ADDR_PC_UPPER && !hwReset)
				pcUpper_q <= hwdata[4:0];
		end
	end
	// ===================================================================
	// AHB-Lite slave: zero wait states, always OKAY.
	always @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			wrPending_q <= 1'b0;
			addr_q <= 12'h000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
		else
		begin
			wrPending_q <= takeTransfer & hwrite & (htrans == TR_NONSEQ);
			if (takeTransfer)
				addr_q <= haddr[11:0];
		end
	end
	// Read data is registered in the address phase so it stands during the data phase.
	always @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			hrdata <= 32'h0000_0000;
		else if (takeTransfer && !hwrite)
		begin
			case (haddr[11:0])
				`RC_ADDR_POWER_STATUS: hrdata <= {24'h00_0000, powerStatus};
				`RC_ADDR_CORE_STATUS: hrdata <= {24'h00_0000, coreStatus_q};
				`RC_ADDR_PC: hrdata <= {19'h0_0000, programCounter};
				`RC_ADDR_INT_CONTROL: hrdata <= {24'h00_0000, intControl_q};
				`RC_ADDR_PC_UPPER: hrdata <= {27'h000_0000, pcUpper_q};
				`RC_ADDR_CONTROL: hrdata <= {29'h000_0000, brownoutEnable, useTimer, crystalMode};
				`RC_ADDR_SEQ_STATE: hrdata <= {28'h000_0000, state_q};
				default: hrdata <= 32'h0000_0000;
			endcase
		end
	end
endmodule // reset_cause_and_timeout

// [dv/reset_cause_checker.sv]
// Timing assertions for the reset-cause block.
`timescale 1ns/1ps
module reset_cause_checker (
	input wire clk,
	input wire sys_rst,
	input wire powerOnEvent,
	input wire watchdogEvent,
	input wire interruptEvent,
	input wire crystalMode,
	input wire powerupTimerEnable_n,
	input wire brownoutEnable,
	input wire coreResetHold,
	input wire coreSleeping,
	input wire pcLoad,
	input wire wakeFlagSet
);
	// =====================================================================
	// Assertions, sized for a 20-cycle power-up and an 8-cycle start-up count.
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);
	a_hold_start: assert property (powerOnEvent && (crystalMode || !powerupTimerEnable_n || brownoutEnable)
		|=> coreResetHold) else $error("hold not raised");
	a_hold_min: assert property (powerOnEvent && (!powerupTimerEnable_n || brownoutEnable) |=> coreResetHold[*8])
		else $error("power-up hold too short");
	a_hold_end: assert property (powerOnEvent |-> ##[1:60] !coreResetHold) else $error("hold never ends");
	a_no_delay: assert property (powerOnEvent && !crystalMode && powerupTimerEnable_n && !brownoutEnable
		|-> ##[1:3] !coreResetHold) else $error("delay without timer");
	a_xtal_only: assert property (powerOnEvent && crystalMode |=> coreResetHold[*6])
		else $error("start-up delay missing");
	a_wake_flag: assert property ((interruptEvent || watchdogEvent) && coreSleeping |-> ##[1:20] wakeFlagSet)
		else $error("wake without flag");
	a_wake_delay: assert property (interruptEvent && coreSleeping && crystalMode |=> !pcLoad[*6])
		else $error("crystal wake too early");
	a_rc_wake: assert property (interruptEvent && coreSleeping && !crystalMode |-> ##[1:3] pcLoad)
		else $error("rc wake delayed");
	c_por: cover property (powerOnEvent ##[1:60] $fell(coreResetHold));
	c_wake: cover property (coreSleeping ##1 pcLoad);
	c_watchdog: cover property (watchdogEvent && coreSleeping);
endmodule // reset_cause_checker
bind reset_cause_and_timeout reset_cause_checker u_chk (.clk, .sys_rst, .powerOnEvent, .watchdogEvent,
	.interruptEvent, .crystalMode, .powerupTimerEnable_n, .brownoutEnable, .coreResetHold, .coreSleeping,
	.pcLoad, .wakeFlagSet);

// [dv/tb.sv]
// Self-checking testbench for the reset-cause block.
`timescale 1ns/1ps
module tb;
	logic clk = 0, sys_rst = 1, hsel = 1, hwrite = 0, hreadyout, hresp, coreResetHold, coreSleeping, pcLoad, wfs;
	logic [31:0] haddr = 0, hwdata = 0, hrdata, r, wd;
	logic [1:0] htrans = 0;
	logic [5:0] evt = 0;
	logic [2:0] cfg = 0;
	logic [2:0] cfgList [6] = '{3'h0, 3'h2, 3'h3, 3'h1, 3'h6, 3'h5};
	logic [12:0] programCounter;
	int error_cnt = 0, comparisons = 0, n;
	// =====================================================================
	// Clock and design.
	always #5 clk = ~clk;
	reset_cause_and_timeout #(.POWERUP_CYCLES(20), .STARTUP_CYCLES(8)) u_reset_cause_and_timeout (.clk, .sys_rst,
		.hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
		.powerOnEvent(evt[0]), .brownoutEvent(evt[1]), .externalResetPin(evt[2]), .watchdogEvent(evt[3]),
		.interruptEvent(evt[4]), .sleepRequest(evt[5]), .crystalMode(cfg[0]), .powerupTimerEnable_n(cfg[1]),
		.brownoutEnable(cfg[2]), .coreResetHold, .coreSleeping, .programCounter, .pcLoad, .wakeFlagSet(wfs));
	// =====================================================================
	// Tasks.
	task automatic report_and_stop();
		$display("errors %0d comparisons %0d", error_cnt, comparisons);
		if (error_cnt == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e)
		begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask
	// Waits for a sampled level, counting edges; a used-up bound ends the run.
	task automatic waitSig(input int k, input logic v);
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while ((k == 0 ? hreadyout : k == 1 ? coreResetHold : pcLoad) !== v && n < 300);
		if (n >= 300)
		begin
			error_cnt++;
			report_and_stop();
		end
	endtask
	task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
		haddr <= {20'h0_0000, a};
		htrans <= 2'h2;
		hwrite <= w;
		waitSig(0, 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		waitSig(0, 1'b1);
		r = hrdata;
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
		bus(1'b0, a, 32'h0000_0000);
		chk("readData", e, r & m);
		chk("hresp", 0, hresp);
	endtask
	// One-cycle event, optionally followed at once by a second one; evt changes once per edge.
	task automatic pulse(input int k, input int k2 = 6);
		evt <= 6'h01 << k;
		@(posedge clk);
		if (k2 < 6)
		begin
			evt <= 6'h01 << k2;
			@(posedge clk);
		end
		evt <= 6'h00;
	endtask
	// =====================================================================
	// Main sequence.
	initial
	begin
		void'($urandom(11995));
		foreach (cfgList[i])
		begin
			sys_rst <= 1'b1;
			cfg <= cfgList[i];
			repeat (10) @(posedge clk);
			sys_rst <= 1'b0;
			@(posedge clk);
			pulse(0);
			waitSig(1, 1'b0);
			chk("holdCycles", ((!cfg[1] || cfg[2]) ? 20 : 0) + (cfg[0] ? 8 : 0) + 1, n);
			rd(12'h000, 2, 0);
			rd(12'h004, 32'h18, 32'h18);
			rd(12'h010, 32'hFFFF_FFFF, 0);
			if (!cfg[0])
			begin
				pulse(5, 4);
				waitSig(2, 1'b1);
				chk("rcWake", 1, n);
				chk("rcWakePc", 13'h0001, programCounter);
				chk("wakeFlag", 1, wfs);
				chk("awake", 0, coreSleeping);
			end
			$display("power-on test %0d done", i);
		end
		repeat (4)
		begin
			wd = $urandom & 32'h0000_0003;
			bus(1'b1, 12'h000, wd);
			rd(12'h000, 32'hFFFF_FFFF, wd);
		end
		bus(1'b1, 12'h000, 32'h0000_0003);
		rd(12'h040, 32'hFFFF_FFFF, 0);
		pulse(1);
		waitSig(1, 1'b0);
		chk("brownoutHold", 29, n);
		rd(12'h000, 32'hFFFF_FFFF, 2);
		bus(1'b1, 12'h000, 32'h0000_0003);
		pulse(3);
		waitSig(1, 1'b0);
		rd(12'h004, 32'h18, 32'h08);
		pulse(2);
		waitSig(1, 1'b0);
		rd(12'h004, 32'h18, 32'h08);
		rd(12'h000, 32'hFFFF_FFFF, 3);
		$display("reset-cause test done");
		bus(1'b1, 12'h00C, 32'h0000_0080);
		pulse(5, 3);
		waitSig(2, 1'b1);
		chk("watchdogWakeWait", 9, n);
		chk("watchdogWakePc", 13'h0001, programCounter);
		rd(12'h004, 32'h18, 0);
		pulse(5, 4);
		waitSig(2, 1'b1);
		chk("wakePc", 13'h0004, programCounter);
		chk("wakeWait", 9, n);
		rd(12'h004, 32'h18, 32'h10);
		rd(12'h00C, 32'h0000_00FF, 32'h0000_0081);
		pulse(5, 2);
		waitSig(1, 1'b0);
		rd(12'h004, 32'h18, 32'h10);
		$display("sleep test done");
		report_and_stop();
	end
endmodule // tb
